// >>> adcsr_pkg.sv
// Purpose: shared constants and carriers of the converter control block
// Assumes: one 100 MHz clock which also serves as the master clock
// Notes: register offsets are byte addresses of 32-bit words
`default_nettype none
package adcsr_pkg;

	// clock and timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int MASTER_CLOCK_PERIOD_NS = 10;
	localparam int UPDATE_BLANK_NS = 500 * MASTER_CLOCK_PERIOD_NS;
	localparam int UPDATE_BLANK_CYCLES_I = UPDATE_BLANK_NS / CLK_PERIOD_NS;
	localparam logic [9:0] UPDATE_BLANK_CYCLES = 10'(UPDATE_BLANK_CYCLES_I);
	localparam int SETTLE_PERIODS = 3;

	// register map
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_RATE = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h8;
	localparam logic [3:0] ADDR_DATA = 4'hc;

	// control fields and reset values
	localparam int CTRL_SYNC_BIT = 0;
	localparam int CTRL_STANDBY_REQUEST_BIT = 1;
	localparam logic CTRL_SYNC_RST = 1'b0;
	localparam logic CTRL_STANDBY_REQUEST_RST = 1'b0;
	localparam logic [15:0] RATE_RST = 16'h0100;
	localparam logic [15:0] DATA_RST = 16'h0000;

	// status fields
	localparam int STAT_DATA_READY_N_BIT = 0;
	localparam int STAT_SETTLE_BIT = 1;
	localparam int STAT_RUN_BIT = 2;
	localparam int STAT_STANDBY_REQUEST_BIT = 3;
	localparam int STAT_PINRST_BIT = 4;

	// converter sequencing states, gray along idle-settle-run
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SETTLE = 2'b01,
		ST_RUN = 2'b11,
		ST_STANDBY_REQUEST = 2'b10
	} adcsr_state_t;

	// register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [31:0] wdata;
	} adcsr_req_t;

endpackage
`default_nettype wire

// >>> adcsr_sync.sv
// Purpose: two-stage synchroniser for pins from outside the clock domain
// Assumes: synchronous active-high reset
// Notes: first stage feeds the second stage only
`timescale 1ns/100ps
`default_nettype none
module adcsr_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic [W-1:0] async_in,
	output var logic [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	// plain double flop, reset to a safe level
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			meta_q <= RST_VAL;
			sync_out <= RST_VAL;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule
`default_nettype wire

// >>> adcsr_ctrl.sv
// Purpose: sync, reset-pin and standby control of a sigma-delta converter
// Assumes: clk_sys is the master clock; filter words come on this clock
// Notes: register port answers reads one cycle later, never stalls
//        rates below the 500-clock gap fold several words into one
//
// Overview of operation
// - sync bit at one holds modulator and filter reset, no sampling
// - writing sync zero releases filter, sampling restarts next edge
// - after sync release no output word before three rate periods
// - host writes sync to start conversion; ready falling marks done
// - low ready stays low when sync returns to zero
// - update while ready low: ready high 500 master clocks, then low
// - data read sets ready high until settled new word arrives
// - ready already high at sync stays high through settling
// - reset pin low clears logic, filter, modulator and registers
// - reset pin low forces ready high and ignores register access
// - after reset pin release, ready low three rate periods later
// - master clock output keeps running during reset pin low
// - standby bit stops conversion, all registers keep contents
// - standby zero resumes, new word three rate periods later
// - standby leaves interface and ready state untouched
// - unread word readable in standby; read sets ready high
// - oscillator and master clock output run during standby
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module adcsr_ctrl
	import adcsr_pkg::*;
#(
	parameter int DATA_W = 16,
	parameter int RATE_W = 16
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic reset_pin_n,
	input wire adcsr_req_t bus_req,
	input wire logic [DATA_W-1:0] filter_word,
	output var logic [31:0] rdata,
	output var logic data_ready_n,
	output var logic filter_reset,
	output var logic conv_power,
	output var logic mclk_out
);
	localparam int CNT_W = RATE_W + 2;

	// three rate periods, a zero rate taken as one cycle
	function automatic logic [CNT_W-1:0] settle_len(
		input logic [RATE_W-1:0] per
	);
		logic [CNT_W-1:0] p;
		p = (per == '0) ? CNT_W'(1) : CNT_W'(per);
		return CNT_W'(SETTLE_PERIODS) * p;
	endfunction

	function automatic logic [CNT_W-1:0] period_len(
		input logic [RATE_W-1:0] per
	);
		return (per == '0) ? CNT_W'(1) : CNT_W'(per);
	endfunction

	// register select, shared by the write and read paths
	function automatic logic reg_hit(
		input adcsr_req_t req,
		input logic [3:0] offs
	);
		return req.addr == offs;
	endfunction

	logic pin_n_s;
	adcsr_state_t state_q, state_d;
	logic sync_hold_q, sync_hold_d;
	logic standby_request_q, standby_request_d;
	logic [RATE_W-1:0] rate_q, rate_d;
	logic [DATA_W-1:0] data_q, data_d;
	logic [DATA_W-1:0] pend_q, pend_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [9:0] blank_q, blank_d;
	logic data_ready_n_q, data_ready_n_d;
	logic [31:0] rdata_d;
	logic freset_d, power_d;
	logic mclk_q;
	logic pin_low, wr_ok, rd_ok, update;

	// reset pin arrives from outside the clock domain
	adcsr_sync #(
		.W(1),
		.RST_VAL(1'b0)
	) u_pin_sync (
		.clk_sys(clk_sys),
		.srst(srst),
		.async_in(reset_pin_n),
		.sync_out(pin_n_s)
	);

	// bus qualification
	// one gate for both strobes, so pin reset never half-applies
	always_comb begin
		pin_low = ~pin_n_s;
		wr_ok = bus_req.wr & ~pin_low;
		rd_ok = bus_req.rd & ~pin_low;
	end

	// control registers written by software
	always_comb begin
		sync_hold_d = sync_hold_q;
		standby_request_d = standby_request_q;
		rate_d = rate_q;
		if (pin_low) begin
			sync_hold_d = CTRL_SYNC_RST;
			standby_request_d = CTRL_STANDBY_REQUEST_RST;
			rate_d = RATE_RST;
		end else if (wr_ok && reg_hit(bus_req, ADDR_CTRL)) begin
			sync_hold_d = bus_req.wdata[CTRL_SYNC_BIT];
			standby_request_d = bus_req.wdata[CTRL_STANDBY_REQUEST_BIT];
		end else if (wr_ok && reg_hit(bus_req, ADDR_RATE)) begin
			// new period is used from the next reload only
			rate_d = bus_req.wdata[RATE_W-1:0];
		end
	end

	// conversion sequencing and settling counter
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		update = 1'b0;
		unique case (state_q)
			ST_IDLE: begin
				if (!pin_low && !standby_request_q && !sync_hold_q) begin
					state_d = ST_SETTLE;
					cnt_d = settle_len(rate_q);
				end else if (!pin_low && standby_request_q) begin
					// standby may be entered straight from idle
					state_d = ST_STANDBY_REQUEST;
				end
			end
			ST_SETTLE, ST_RUN: begin
				// a rate change lands only at the next reload
				if (cnt_q <= CNT_W'(1)) begin
					update = 1'b1;
					state_d = ST_RUN;
					cnt_d = period_len(rate_q);
				end else begin
					cnt_d = cnt_q - CNT_W'(1);
				end
				if (standby_request_q) begin
					state_d = ST_STANDBY_REQUEST;
					update = 1'b0;
				end
			end
			ST_STANDBY_REQUEST: begin
				// resume with three periods of settling
				if (!standby_request_q) begin
					// hold set on exit parks the sequencer in idle
					state_d = sync_hold_q ? ST_IDLE : ST_SETTLE;
					cnt_d = settle_len(rate_q);
				end
			end
		endcase
		if (sync_hold_q && state_d != ST_STANDBY_REQUEST) begin
			state_d = ST_IDLE;
			update = 1'b0;
		end
		// applied last so no branch above can override it
		// reset pin clears the sequencer
		if (pin_low) begin
			state_d = ST_IDLE;
			cnt_d = '0;
			update = 1'b0;
		end
	end

	// data register and ready line
	always_comb begin
		data_d = data_q;
		pend_d = pend_q;
		data_ready_n_d = data_ready_n_q;
		blank_d = blank_q;
		// completed data read sets ready high
		if (rd_ok && reg_hit(bus_req, ADDR_DATA)) begin
			data_ready_n_d = 1'b1;
		end
		// gap countdown, last cycle loads the held word
		if (blank_q != '0) begin
			blank_d = blank_q - 10'(1);
			if (blank_q == 10'(1)) begin
				data_d = pend_q;
				data_ready_n_d = 1'b0;
			end
		end
		if (update) begin
			if (!data_ready_n_q && blank_q == '0) begin
				// high gap before replacing unread word
				pend_d = filter_word;
				blank_d = UPDATE_BLANK_CYCLES;
				data_ready_n_d = 1'b1;
			end else if (blank_q != '0) begin
				// gap running: only the held word is refreshed
				pend_d = filter_word;
			end else begin
				// new word wins over a read in the same cycle
				data_d = filter_word;
				data_ready_n_d = 1'b0;
			end
		end
		// sync and standby never touch ready
		// pin reset comes last so it beats reads and updates
		if (pin_low) begin
			data_ready_n_d = 1'b1;
			blank_d = '0;
			data_d = DATA_RST;
			pend_d = DATA_RST;
		end
	end

	// read data and registered drive outputs
	always_comb begin
		rdata_d = '0;
		if (rd_ok) begin
			unique case (bus_req.addr)
				ADDR_CTRL: begin
					rdata_d[CTRL_SYNC_BIT] = sync_hold_q;
					rdata_d[CTRL_STANDBY_REQUEST_BIT] = standby_request_q;
				end
				ADDR_RATE: rdata_d[RATE_W-1:0] = rate_q;
				ADDR_STATUS: begin
					rdata_d[STAT_DATA_READY_N_BIT] = data_ready_n_q;
					rdata_d[STAT_SETTLE_BIT] = (state_q == ST_SETTLE);
					rdata_d[STAT_RUN_BIT] = (state_q == ST_RUN);
					rdata_d[STAT_STANDBY_REQUEST_BIT] = (state_q == ST_STANDBY_REQUEST);
					// reads 0 whenever the port answers at all
					rdata_d[STAT_PINRST_BIT] = pin_low;
				end
				ADDR_DATA: rdata_d[DATA_W-1:0] = data_q;
				// unmapped offsets read as zero
				default: rdata_d = '0;
			endcase
		end
		// hold keeps the filter in reset even in standby
		freset_d = (state_d == ST_IDLE) ||
			(state_d == ST_STANDBY_REQUEST && sync_hold_q);
		power_d = (state_d != ST_STANDBY_REQUEST);
	end

	// register stage
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_q <= ST_IDLE;
			sync_hold_q <= CTRL_SYNC_RST;
			standby_request_q <= CTRL_STANDBY_REQUEST_RST;
			rate_q <= RATE_RST;
			data_q <= DATA_RST;
			pend_q <= DATA_RST;
			cnt_q <= '0;
			blank_q <= '0;
			data_ready_n_q <= 1'b1;
			rdata <= '0;
			filter_reset <= 1'b1;
			conv_power <= 1'b1;
		end else begin
			state_q <= state_d;
			sync_hold_q <= sync_hold_d;
			standby_request_q <= standby_request_d;
			rate_q <= rate_d;
			data_q <= data_d;
			pend_q <= pend_d;
			cnt_q <= cnt_d;
			blank_q <= blank_d;
			data_ready_n_q <= data_ready_n_d;
			rdata <= rdata_d;
			filter_reset <= freset_d;
			conv_power <= power_d;
		end
	end

	assign data_ready_n = data_ready_n_q;

	// master clock out, half rate; ignores the pin and standby on purpose
	// clock through pin reset
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			mclk_q <= 1'b0;
		end else begin
			mclk_q <= ~mclk_q;
		end
	end

	assign mclk_out = mclk_q;
endmodule
`default_nettype wire

// >>> adcsr_chk_assertions.sv
// Purpose: port checks of the converter control block
// Assumes: pin reset pulses last six cycles or more
// Notes: settle spans hang on the rate, so the bench times them
`timescale 1ns/100ps
`default_nettype none
module adcsr_chk
	import adcsr_pkg::*;
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic reset_pin_n,
	input wire adcsr_req_t bus_req,
	input wire logic [31:0] rdata,
	input wire logic data_ready_n,
	input wire logic filter_reset,
	input wire logic conv_power,
	input wire logic mclk_out
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	// pin level as seen past the two-flop sync
	sequence pin_low;
		!reset_pin_n [*4];
	endsequence
	sequence pin_high;
		reset_pin_n [*6];
	endsequence
	// master clock never pauses, pin reset or standby alike
	a_mclk_runs: assert property (
		!$past(srst) |-> $changed(mclk_out))
		else $error("mclk stalled");
	a_pin_ready: assert property (pin_low |-> data_ready_n)
		else $error("ready low in pin reset");
	a_pin_filter: assert property (pin_low |-> filter_reset)
		else $error("filter free in pin reset");
	a_hold_filter: assert property (
		pin_high ##0 (bus_req.wr && bus_req.addr == ADDR_CTRL &&
		bus_req.wdata[CTRL_SYNC_BIT]) |-> ##2 filter_reset)
		else $error("filter free while sync held");
	a_pin_deaf: assert property (
		pin_low ##0 bus_req.rd |=> rdata == '0)
		else $error("read answered in pin reset");
	a_standby_request_read: assert property (
		pin_high ##0 (bus_req.rd && bus_req.addr == ADDR_DATA &&
		!conv_power) |=> data_ready_n)
		else $error("standby read left ready low");
	// only a word held by a running gap can arrive while held or powered down
	a_halt_high: assert property (
		(filter_reset || !conv_power) && data_ready_n |=> data_ready_n)
		else $error("ready fell while halted");
	a_sync_low: assert property (
		$fell(filter_reset) && !data_ready_n && !bus_req.rd
		|=> !data_ready_n)
		else $error("release dropped unread word");
	a_gap_min: assert property (
		pin_high ##0 ($rose(data_ready_n) && !$past(bus_req.rd) &&
		!filter_reset) |-> data_ready_n [*8])
		else $error("update gap too short");
endmodule
bind adcsr_ctrl adcsr_chk chk_u (.clk_sys, .srst, .reset_pin_n, .bus_req,
	.rdata, .data_ready_n, .filter_reset, .conv_power, .mclk_out);
`default_nettype wire

// >>> adcsr_host.sv
// Purpose: host model on the register port
// Assumes: strobes launched just after a rising edge
// Notes: one idle cycle after a write, two after a read
`timescale 1ns/100ps
`default_nettype none
module adcsr_host
	import adcsr_pkg::*;
(
	input wire logic clk_sys,
	input wire logic [31:0] rdata,
	output var adcsr_req_t bus_req
);
	initial bus_req = '0;
	task automatic wr(logic [3:0] a, logic [31:0] d);
		@(posedge clk_sys);
		bus_req <= '{1'b1, 1'b0, a, d};
		@(posedge clk_sys);
		bus_req <= '0;
	endtask
	// data stand only in the cycle after the strobe
	task automatic rd(logic [3:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		bus_req <= '{1'b0, 1'b1, a, 32'h0};
		@(posedge clk_sys);
		bus_req <= '0;
		@(posedge clk_sys);
		d = rdata;
	endtask
endmodule
`default_nettype wire

// >>> testbench.sv
// Purpose: self-checking bench of the converter control block
// Assumes: rate of twenty clocks, so settling spans sixty
// Notes: the pin reset brings back the long default rate
`timescale 1ns/100ps
`default_nettype none
module testbench
	import adcsr_pkg::*;
;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic reset_pin_n = 1'b1;
	logic [15:0] fw = 16'ha5c3;
	adcsr_req_t bus_req;
	logic [31:0] rdata, v;
	logic data_ready_n, filter_reset, conv_power;
	int bad_count = 0;
	int check_count = 0;
	int n;
	// 100 MHz
	always #5 clk_sys = ~clk_sys;
	adcsr_ctrl dut_u (.clk_sys, .srst, .reset_pin_n, .bus_req,
		.filter_word(fw), .rdata, .data_ready_n, .filter_reset,
		.conv_power, .mclk_out());
	adcsr_host hst (.clk_sys, .rdata, .bus_req);
	// case equality, so an unknown never matches
	task automatic chk(string s, logic [31:0] e, g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s exp %h got %h", s, e, g);
		end
	endtask
	// edges until ready shows l, capped so a stall ends
	task automatic wait_rdy(string s, logic l, int lo, int hi);
		n = 0;
		while (data_ready_n !== l && n < 2000) begin
			@(posedge clk_sys);
			n++;
		end
		check_count++;
		if (n < lo || n > hi) begin
			bad_count++;
			$display("[ERR] %s exp %0d..%0d got %0d", s, lo, hi, n);
		end
	endtask
	task automatic skip(int k);
		repeat (k) @(posedge clk_sys);
	endtask
	task automatic test_done();
		$display("checks %0d bad %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// run needs some 1600 cycles
	initial begin
		skip(5000);
		bad_count++;
		test_done();
	end
	// main sequence
	initial begin
		skip(8);
		srst <= 1'b0;
		skip(4);
		hst.rd(ADDR_RATE, v);
		chk("rate", 32'(RATE_RST), v);
		hst.wr(ADDR_RATE, 32'h14);
		hst.wr(ADDR_CTRL, 32'h1);
		skip(40);
		chk("hold", 32'h1, 32'(filter_reset));
		chk("rdy", 32'h1, 32'(data_ready_n));
		hst.wr(ADDR_CTRL, 32'h0);
		wait_rdy("settle", 1'b0, 60, 67);
		hst.wr(ADDR_CTRL, 32'h1);
		skip(30);
		chk("held", 32'h0, 32'(data_ready_n));
		hst.wr(ADDR_CTRL, 32'h0);
		skip(30);
		chk("kept", 32'h0, 32'(data_ready_n));
		wait_rdy("rise", 1'b1, 29, 38);
		wait_rdy("gap", 1'b0, 500, 500);
		hst.wr(ADDR_CTRL, 32'h2);
		fw <= 16'h3c5a;
		skip(30);
		chk("power", 32'h0, 32'(conv_power));
		chk("standby_request", 32'h0, 32'(data_ready_n));
		hst.rd(ADDR_STATUS, v);
		chk("status", 32'h1 << STAT_STANDBY_REQUEST_BIT, v);
		hst.rd(ADDR_DATA, v);
		chk("word", 32'ha5c3, v);
		chk("clear", 32'h1, 32'(data_ready_n));
		hst.wr(ADDR_CTRL, 32'h0);
		wait_rdy("wake", 1'b0, 60, 67);
		hst.rd(ADDR_DATA, v);
		chk("new", 32'h3c5a, v);
		// hold and standby together: filter held, power off
		hst.wr(ADDR_CTRL, 32'h3);
		skip(4);
		chk("hold standby_request", 32'h1, 32'(filter_reset));
		chk("power off", 32'h0, 32'(conv_power));
		hst.rd(ADDR_CTRL, v);
		chk("ctrl", 32'h3, v);
		reset_pin_n <= 1'b0;
		skip(10);
		hst.wr(ADDR_RATE, 32'h8);
		hst.rd(ADDR_RATE, v);
		chk("deaf", 32'h0, v);
		reset_pin_n <= 1'b1;
		wait_rdy("pin", 1'b0, 768, 776);
		hst.rd(ADDR_CTRL, v);
		chk("ctrl default", 32'h0, v);
		hst.rd(ADDR_RATE, v);
		chk("default", 32'(RATE_RST), v);
		test_done();
	end
endmodule
`default_nettype wire
